// ### rtl/swspi_digit.sv
/*
  One counter stage of the time chain, counting 0 to MOD-1.
  Assumes the caller chains inc through term of the lower stages.
*/
`include "swspi_regs.svh"

module swspi_digit #(
  parameter int unsigned MOD = `SWSPI_MOD_DEC
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic clr, // synchronous clear to zero
  input wire logic inc, // advance by one
  output swspi_pkg::swspi_digit_t value, // current digit
  output logic term // digit at MOD-1
);
  import swspi_pkg::*;

  localparam swspi_digit_t LAST = swspi_digit_t'(MOD - 1);

  swspi_digit_t value_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      value_reg <= 4'h0;
    end else if (clr) begin
      value_reg <= 4'h0;
    end else if (inc) begin
      value_reg <= (value_reg == LAST) ? 4'h0 : value_reg + 4'h1;
    end
  end

  assign value = value_reg;
  assign term = (value_reg == LAST);

endmodule : swspi_digit

// ### rtl/swspi_pkg.sv
/*
  Types shared by the stopwatch with serial display output.
  Assumes swspi_regs.svh supplies the numeric constants.
*/
`include "swspi_regs.svh"

package swspi_pkg;

  typedef logic [3:0] swspi_digit_t;
  typedef swspi_digit_t [`SWSPI_NUM_DIG-1:0] swspi_time_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic mosi;
  } swspi_spi_s;

  typedef enum logic [4:0] {
    SPI_BOOT  = 5'b00001,
    SPI_LOAD  = 5'b00010,
    SPI_SHIFT = 5'b00100,
    SPI_GAP   = 5'b01000,
    SPI_HOLD  = 5'b10000
  } swspi_spi_state_e;

endpackage : swspi_pkg

// ### rtl/swspi_regs.svh
/*
  Named constants of the stopwatch with serial display output: clock and
  timing figures, display driver register addresses and setup values.
  Assumes inclusion by bare name from every file that needs it.
*/
`ifndef SWSPI_REGS_SVH
`define SWSPI_REGS_SVH

// system clock period and timing figures, in ns
`define SWSPI_CLK_NS 5
`define SWSPI_TICK_NS 10000000
`define SWSPI_SPI_HALF_NS 500

// per-digit counter moduli
`define SWSPI_MOD_DEC 10
`define SWSPI_MOD_SIX 6
`define SWSPI_NUM_DIG 6

// serial frame shape
`define SWSPI_FRAME_BITS 16
`define SWSPI_NUM_INIT 4
`define SWSPI_IDX_W 4

// display driver register addresses
`define SWSPI_ADDR_DIG0 8'h01
`define SWSPI_ADDR_DECODE 8'h09
`define SWSPI_ADDR_INTENS 8'h0A
`define SWSPI_ADDR_SCAN 8'h0B
`define SWSPI_ADDR_SHUTDN 8'h0C

// setup data: raw segments, mid brightness, six digits, normal operation
`define SWSPI_VAL_DECODE 8'h00
`define SWSPI_VAL_INTENS 8'h08
`define SWSPI_VAL_SCAN 8'h05
`define SWSPI_VAL_SHUTDN 8'h01

// decimal point bit and digits that carry it (seconds and minutes ones)
`define SWSPI_DP_BIT 8'h80
`define SWSPI_DP_SEC 2
`define SWSPI_DP_MIN 4

`endif

// ### rtl/swspi_top.sv
/*
  Stopwatch counting hundredths up to 59:59:99, with start/stop, lap
  freeze, counter clear, and a serial master feeding a seven-segment
  display driver with 16-bit frames.
  Assumes buttons are synchronous to CLK_SYS and already debounced.
*/
// Summary of operation
// - Divide the system clock to a 100 Hz tick, one hundredth per tick.
// - Count minutes, seconds, hundredths from 00:00:00 up to 59:59:99.
// - Chain decimal and base-six digit stages, each carrying to the next.
// - Send all six digit values, segment encoded, over the serial master.
// - Each start/stop press toggles between running and halted.
// - Lap press freezes the display while counting continues.
// - A second lap press returns the display to the live count.
// - Counter clear input zeroes only the time digits.
// - Chip reset returns everything, display interface included, to start.
// - Skip-setup input caught at reset omits setup frames, time only.
// - Running output is high while counters are enabled.
// - Display-enabled output is low while a lap value is frozen.
`include "swspi_regs.svh"

module swspi_top #(
  parameter int unsigned TICK_DIV = `SWSPI_TICK_NS / `SWSPI_CLK_NS
) (
  input wire logic CLK_SYS, // 200 MHz system clock
  input wire logic RST, // chip reset, async, active high
  input wire logic START_STOP, // start/stop button, active high
  input wire logic LAP, // lap button, active high
  input wire logic CNT_CLR, // counter clear, active high
  input wire logic SKIP_SETUP, // skip display setup, held over reset
  output swspi_pkg::swspi_spi_s SPI, // serial clock, select, data
  output logic RUNNING, // counters enabled
  output logic DISP_EN // display live, low while frozen
);
  import swspi_pkg::*;

  localparam int unsigned SPI_HALF = `SWSPI_SPI_HALF_NS / `SWSPI_CLK_NS;
  localparam int unsigned NDIG = `SWSPI_NUM_DIG;
  localparam int unsigned NFRM = `SWSPI_NUM_INIT + `SWSPI_NUM_DIG;
  localparam logic [`SWSPI_IDX_W-1:0] IDX_FIRST_DIG =
    `SWSPI_IDX_W'(`SWSPI_NUM_INIT);
  localparam logic [`SWSPI_IDX_W-1:0] IDX_LAST = `SWSPI_IDX_W'(NFRM - 1);
  localparam logic [3:0] BIT_LAST = 4'(`SWSPI_FRAME_BITS - 1);

  // tick divider
  logic [31:0] tick_cnt_reg;
  logic tick;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tick_cnt_reg <= 32'h0;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end

  assign tick = (tick_cnt_reg == 32'(TICK_DIV - 1));

  // button edges
  logic start_prev_reg;
  logic lap_prev_reg;
  logic start_press;
  logic lap_press;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      start_prev_reg <= 1'b0;
      lap_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= START_STOP;
      lap_prev_reg <= LAP;
    end
  end

  assign start_press = START_STOP & ~start_prev_reg;
  assign lap_press = LAP & ~lap_prev_reg;

  // run/stop and lap state
  logic run_reg;
  logic frozen_reg;
  swspi_time_t lap_reg;
  swspi_time_t live;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      run_reg <= 1'b0;
    end else if (start_press) begin
      run_reg <= ~run_reg;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      frozen_reg <= 1'b0;
      lap_reg <= '0;
    end else if (lap_press) begin
      if (!frozen_reg) begin
        frozen_reg <= 1'b1;
        lap_reg <= live;
      end else begin
        frozen_reg <= 1'b0;
      end
    end
  end

  assign RUNNING = run_reg;
  assign DISP_EN = ~frozen_reg;

  // counter chain: hundredths, tenths, seconds, tens of s, min, tens of min
  logic [NDIG:0] inc;
  logic [NDIG-1:0] term;
  logic at_max;

  assign at_max = &term; // holds at 59:59:99
  assign inc[0] = tick & run_reg & ~at_max;

  genvar gi;
  generate
    for (gi = 0; gi < NDIG; gi++) begin : g_dig
      localparam int unsigned MOD = (gi == 3 || gi == 5) ?
        `SWSPI_MOD_SIX : `SWSPI_MOD_DEC;
      swspi_digit #(
        .MOD(MOD)
      ) u_dig (
        .clk(CLK_SYS),
        .rst(RST),
        .clr(CNT_CLR),
        .inc(inc[gi]),
        .value(live[gi]),
        .term(term[gi])
      );
      assign inc[gi+1] = inc[gi] & term[gi];
    end
  endgenerate

  // segment pattern, bit order dp a b c d e f g
  function automatic logic [7:0] seg_of(input swspi_digit_t d);
    case (d)
      4'h0: seg_of = 8'h7E;
      4'h1: seg_of = 8'h30;
      4'h2: seg_of = 8'h6D;
      4'h3: seg_of = 8'h79;
      4'h4: seg_of = 8'h33;
      4'h5: seg_of = 8'h5B;
      4'h6: seg_of = 8'h5F;
      4'h7: seg_of = 8'h70;
      4'h8: seg_of = 8'h7F;
      4'h9: seg_of = 8'h7B;
      default: seg_of = 8'h00;
    endcase
  endfunction : seg_of

  swspi_time_t shown;
  assign shown = frozen_reg ? lap_reg : live;

  // frame word for a sequence index
  function automatic logic [15:0] frame_of(
    input logic [`SWSPI_IDX_W-1:0] idx,
    input swspi_time_t t
  );
    logic [`SWSPI_IDX_W-1:0] dig;
    logic [7:0] data;
    dig = idx - IDX_FIRST_DIG;
    data = 8'h00;
    case (idx)
      4'h0: frame_of = {`SWSPI_ADDR_DECODE, `SWSPI_VAL_DECODE};
      4'h1: frame_of = {`SWSPI_ADDR_INTENS, `SWSPI_VAL_INTENS};
      4'h2: frame_of = {`SWSPI_ADDR_SCAN, `SWSPI_VAL_SCAN};
      4'h3: frame_of = {`SWSPI_ADDR_SHUTDN, `SWSPI_VAL_SHUTDN};
      default: begin
        data = seg_of(t[dig[2:0]]);
        if (dig == `SWSPI_IDX_W'(`SWSPI_DP_SEC) ||
            dig == `SWSPI_IDX_W'(`SWSPI_DP_MIN)) begin
          data = data | `SWSPI_DP_BIT;
        end
        frame_of = {`SWSPI_ADDR_DIG0 + {4'h0, dig}, data};
      end
    endcase
  endfunction : frame_of

  // serial half-period enable
  logic [7:0] half_cnt_reg;
  logic half;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      half_cnt_reg <= 8'h0;
    end else if (half) begin
      half_cnt_reg <= 8'h0;
    end else begin
      half_cnt_reg <= half_cnt_reg + 8'h1;
    end
  end

  assign half = (half_cnt_reg == 8'(SPI_HALF - 1));

  // skip-setup strap, sampled on every edge while reset is held;
  // no reset of its own, so reset must span at least one clock edge
  logic skip_reg;
  logic caught_reg;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      skip_reg <= SKIP_SETUP;
    end
  end

  // one idle cycle after release before the first frame
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      caught_reg <= 1'b0;
    end else if (!caught_reg) begin
      caught_reg <= 1'b1;
    end
  end

  // serial master
  swspi_spi_state_e state_reg;
  logic [15:0] shift_reg;
  logic [3:0] bit_reg;
  logic [`SWSPI_IDX_W-1:0] idx_reg;
  logic sck_reg;
  logic cs_n_reg;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state_reg <= SPI_BOOT;
      shift_reg <= 16'h0;
      bit_reg <= 4'h0;
      idx_reg <= 4'h0;
      sck_reg <= 1'b0;
      cs_n_reg <= 1'b1;
    end else begin
      case (state_reg)
        SPI_BOOT: begin
          if (caught_reg) begin
            idx_reg <= skip_reg ? IDX_FIRST_DIG : 4'h0;
            state_reg <= SPI_LOAD;
          end
        end
        SPI_LOAD: begin
          shift_reg <= frame_of(idx_reg, shown);
          bit_reg <= BIT_LAST;
          cs_n_reg <= 1'b0;
          sck_reg <= 1'b0;
          state_reg <= SPI_SHIFT;
        end
        SPI_SHIFT: begin
          if (half) begin
            if (!sck_reg) begin
              sck_reg <= 1'b1;
            end else begin
              sck_reg <= 1'b0;
              if (bit_reg == 4'h0) begin
                state_reg <= SPI_GAP;
              end else begin
                bit_reg <= bit_reg - 4'h1;
                shift_reg <= {shift_reg[14:0], 1'b0}; // msb first
              end
            end
          end
        end
        SPI_GAP: begin
          if (half) begin
            cs_n_reg <= 1'b1; // rising edge latches frame
            state_reg <= SPI_HOLD;
          end
        end
        SPI_HOLD: begin
          if (half) begin
            idx_reg <= (idx_reg == IDX_LAST) ? IDX_FIRST_DIG :
              idx_reg + 4'h1;
            state_reg <= SPI_LOAD;
          end
        end
        default: begin
          state_reg <= SPI_BOOT;
          cs_n_reg <= 1'b1;
          sck_reg <= 1'b0;
        end
      endcase
    end
  end

  assign SPI.sck = sck_reg;
  assign SPI.cs_n = cs_n_reg;
  assign SPI.mosi = shift_reg[15];

endmodule : swspi_top

// ### test/swspi_disp_model.sv
/* Display driver model latching 16-bit frames on select release.
   Assumes it only listens on the serial pins. */
module swspi_disp_model (
  input wire logic clk, // system clock
  input wire logic rst, // chip reset
  input wire swspi_pkg::swspi_spi_s spi, // serial pins
  output logic [15:0] frame, // last latched frame
  output int unsigned count // frames latched
);
  timeunit 1ns;
  timeprecision 100ps;
  import swspi_pkg::*;
  logic [15:0] shift_reg;
  logic sck_reg;
  logic cs_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_reg <= 1'b0;
      cs_reg <= 1'b1;
      shift_reg <= 16'h0000;
      frame <= 16'h0000;
      count <= 0;
    end else begin
      sck_reg <= spi.sck;
      cs_reg <= spi.cs_n;
      if (!spi.cs_n && spi.sck && !sck_reg)
        shift_reg <= {shift_reg[14:0], spi.mosi};
      if (spi.cs_n && !cs_reg) begin
        frame <= shift_reg;
        count <= count + 1;
      end
    end
  end
endmodule : swspi_disp_model

// ### test/swspi_props.sv
/* Checker for the stopwatch top ports.
   Assumes a bind onto swspi_top. */
module swspi_props (
  input wire logic CLK_SYS, // clock
  input wire logic RST, // chip reset
  input wire logic START_STOP, // run button
  input wire logic LAP, // lap button
  input wire logic CNT_CLR, // counter clear
  input wire logic SKIP_SETUP, // setup skip strap
  input wire swspi_pkg::swspi_spi_s SPI, // serial pins
  input wire logic RUNNING, // counting
  input wire logic DISP_EN // display live
);
  timeunit 1ns;
  timeprecision 100ps;
  import swspi_pkg::*;
  logic [4:0] bits_reg;
  logic sck_reg;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // rising serial clocks inside the current frame
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      bits_reg <= 5'h00;
      sck_reg <= 1'b0;
    end else begin
      sck_reg <= SPI.sck;
      if (SPI.cs_n)
        bits_reg <= 5'h00;
      else if (SPI.sck && !sck_reg)
        bits_reg <= bits_reg + 5'h01;
    end
  end
  sequence sck_rise_s; $rose(SPI.sck); endsequence
  sequence sck_fall_s; $fell(SPI.sck); endsequence
  run_toggle_a: assert property ($rose(START_STOP) |=>
    RUNNING != $past(RUNNING)) else $error("run state did not toggle");
  run_hold_a: assert property (!$rose(START_STOP) |=>
    $stable(RUNNING)) else $error("run state moved without press");
  lap_toggle_a: assert property ($rose(LAP) |=>
    DISP_EN != $past(DISP_EN)) else $error("display state did not toggle");
  lap_hold_a: assert property (!$rose(LAP) |=>
    $stable(DISP_EN)) else $error("display state moved without press");
  sck_framed_a: assert property ($changed(SPI.sck) |->
    !SPI.cs_n) else $error("serial clock moved outside frame");
  sck_half_a: assert property (sck_rise_s |-> ##100 sck_fall_s)
    else $error("serial clock high time wrong");
  mosi_stable_a: assert property (SPI.sck |-> $stable(SPI.mosi))
    else $error("data moved while clock high");
  frame_len_a: assert property ($rose(SPI.cs_n) |-> bits_reg == 5'h10)
    else $error("frame not sixteen bits");
endmodule : swspi_props

bind swspi_top swspi_props swspi_props_i (.CLK_SYS(CLK_SYS), .RST(RST),
  .START_STOP(START_STOP), .LAP(LAP), .CNT_CLR(CNT_CLR),
  .SKIP_SETUP(SKIP_SETUP), .SPI(SPI), .RUNNING(RUNNING), .DISP_EN(DISP_EN));

// ### test/test_swspi_top.sv
/* Self-checking bench of the stopwatch: frames, buttons, resets.
   Assumes the display model and the bound checker. */
module test_swspi_top;
  timeunit 1ns;
  timeprecision 100ps;
  import swspi_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic start_stop = 1'b0;
  logic lap = 1'b0;
  logic cnt_clr = 1'b0;
  logic skip_setup = 1'b0;
  swspi_spi_s spi;
  logic running;
  logic disp_en;
  logic [15:0] frame;
  int unsigned count;
  int error_cnt = 0;
  int compares = 0;
  logic [15:0] rows [6] = '{16'h0900, 16'h0A08, 16'h0B05, 16'h0C01,
    16'h017E, 16'h027E};

  swspi_top #(.TICK_DIV(50)) swspi_top_i (.CLK_SYS(clk), .RST(rst),
    .START_STOP(start_stop), .LAP(lap), .CNT_CLR(cnt_clr),
    .SKIP_SETUP(skip_setup), .SPI(spi), .RUNNING(running),
    .DISP_EN(disp_en));
  swspi_disp_model swspi_disp_model_i (.clk(clk), .rst(rst), .spi(spi),
    .frame(frame), .count(count));

  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic get_frame(output logic [15:0] f);
    int unsigned n;
    n = count;
    for (int i = 0; i < 5000 && count == n; i++) @(negedge clk);
    f = frame;
    if (count == n) begin
      error_cnt++;
      $display("[ERR] %0t no frame arrived", $time);
      complete_run();
    end
  endtask : get_frame

  // one press of start/stop (k 0) or lap (k 1)
  task automatic press(input int k);
    @(negedge clk);
    if (k == 0) start_stop = 1'b1;
    else lap = 1'b1;
    @(negedge clk);
    start_stop = 1'b0;
    lap = 1'b0;
  endtask : press

  task automatic do_reset(input logic skip);
    @(negedge clk);
    rst = 1'b1;
    skip_setup = skip;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    skip_setup = 1'b0; // strap only counts while reset is held
  endtask : do_reset

  initial begin
    logic [15:0] f;
    do_reset(1'b0);
    for (int r = 0; r < 6; r++) begin
      get_frame(f);
      check(f, rows[r]);
    end
    press(0);
    check({15'h0000, running}, 16'h0001);
    press(1);
    check({15'h0000, disp_en}, 16'h0000);
    get_frame(f);
    check(f, 16'h03FE);
    repeat (6) get_frame(f);
    check(f, 16'h03FE);
    press(1);
    check({15'h0000, disp_en}, 16'h0001);
    repeat (6) get_frame(f);
    check({15'h0000, f !== 16'h03FE}, 16'h0001);
    cnt_clr = 1'b1;
    get_frame(f);
    get_frame(f);
    check(f, 16'h05FE);
    check({14'h0000, running, disp_en}, 16'h0003);
    cnt_clr = 1'b0;
    press(1);
    do_reset(1'b1);
    check({14'h0000, running, disp_en}, 16'h0001);
    get_frame(f);
    check(f, 16'h017E);
    complete_run();
  end
endmodule : test_swspi_top
